// [ocs_pkg.sv]
// Package for one overcurrent stage: blocking, start, events, fault records.
// Assumes a single 20 MHz clock and an APB master on the same clock.
package ocs_pkg;

  localparam int unsigned CLK_HZ        = 20_000_000;
  localparam int unsigned PROG_CYCLE_US = 5000;
  localparam int unsigned MS_US         = 1000;
  localparam int unsigned PROG_CYC      = CLK_HZ / 1_000_000 * PROG_CYCLE_US;
  localparam int unsigned MS_CYC        = CLK_HZ / 1_000_000 * MS_US;
  localparam int unsigned BLOCK_LEAD_MS = 5;
  localparam int unsigned HIST_STEP_MS  = 20;
  localparam int unsigned HIST_DEPTH    = 10;
  localparam int unsigned REC_DEPTH     = 12;
  localparam int unsigned RESET_PCT     = 97;
  localparam int unsigned FULL_PCT      = 100;
  localparam int unsigned NUM_EVT       = 9;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_ISET   = 8'h04;
  localparam logic [7:0] OFS_HLIM   = 8'h08;
  localparam logic [7:0] OFS_OPDLY  = 8'h0C;
  localparam logic [7:0] OFS_RELDLY = 8'h10;
  localparam logic [7:0] OFS_ONEN   = 8'h14;
  localparam logic [7:0] OFS_OFFEN  = 8'h18;
  localparam logic [7:0] OFS_STAT   = 8'h1C;
  localparam logic [7:0] OFS_CSTART = 8'h20;
  localparam logic [7:0] OFS_CTRIP  = 8'h24;
  localparam logic [7:0] OFS_CBLK   = 8'h28;
  localparam logic [7:0] OFS_RSEL   = 8'h2C;
  localparam logic [7:0] OFS_RDATA  = 8'h30;
  localparam logic [7:0] OFS_RCNT   = 8'h34;
  localparam logic [7:0] OFS_IDMTK  = 8'h38;

  // CTRL fields
  localparam int unsigned CTRL_IDMT   = 0;
  localparam int unsigned CTRL_INRUSH = 1;
  localparam int unsigned CTRL_CLRCNT = 2;

  // Reset values
  localparam logic [15:0] ISET_RST  = 16'h04B0;
  localparam logic [15:0] HLIM_RST  = 16'h0001;
  localparam logic [20:0] OPDLY_RST = 21'h000064;
  localparam logic [20:0] RELDLY_RST = 21'h000000;
  localparam logic [31:0] IDMTK_RST = 32'h00010000;
  localparam logic [8:0]  EVEN_RST  = 9'h1FF;

  // Event indices
  localparam int unsigned EV_START = 0;
  localparam int unsigned EV_TRIP  = 1;
  localparam int unsigned EV_BLOCK = 2;
  localparam int unsigned EV_STPH  = 3;
  localparam int unsigned EV_TRPH  = 6;

  typedef enum logic [1:0] {
    OCS_K_START,
    OCS_K_TRIP,
    OCS_K_BLOCK
  } ocs_kind_t;

  typedef struct packed {
    logic        valid;
    logic [3:0]  idx;
    logic        on;
    logic [47:0] ts;
  } ocs_evt_t;

  typedef struct packed {
    logic [47:0] ts;
    logic [1:0]  kind;
    logic [2:0]  phases;
    logic [15:0] pre_trig;
    logic [15:0] fault;
    logic [15:0] pre_fault;
    logic [20:0] remain;
    logic [2:0]  group;
  } ocs_rec_t;

endpackage

// [ocs_rec_store.sv]
// Circular store of fault records, flip-flop storage.
// Assumes writes and reads from the stage logic on the same clock.
`timescale 1ns/1ps
module ocs_rec_store
  import ocs_pkg::*;
#(
  parameter int unsigned DEPTH = REC_DEPTH
) (
  input  wire logic     i_sys_clk,
  input  wire logic     i_reset,
  input  wire logic     i_wr,
  input  wire ocs_rec_t i_rec,
  input  wire logic [3:0] i_rd_idx,
  output ocs_rec_t      o_rd_rec,
  output logic [3:0]    o_count
);

  initial begin
    if (DEPTH < 2 || DEPTH > 15) begin
      $error("ocs_rec_store: DEPTH out of range");
    end
  end

  ocs_rec_t   mem_q [DEPTH];
  logic [3:0] wptr_q;
  logic [3:0] cnt_q;
  logic [4:0] slot;

  // Oldest entry is overwritten once full
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      wptr_q <= 4'h0;
      cnt_q  <= 4'h0;
    end else if (i_wr) begin
      wptr_q <= (wptr_q == 4'(DEPTH - 1)) ? 4'h0 : wptr_q + 4'h1;
      if (cnt_q != 4'(DEPTH)) begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_wr) begin
      mem_q[wptr_q] <= i_rec;
    end
  end

  // Index 0 is the newest record
  always_comb begin
    slot = {1'b0, wptr_q} + 5'(DEPTH) - 5'h01 - {1'b0, i_rd_idx};
    if (slot >= 5'(DEPTH)) begin
      slot = slot - 5'(DEPTH);
    end
    o_rd_rec = (i_rd_idx < cnt_q) ? mem_q[slot[3:0]] : '0;
  end

  assign o_count = cnt_q;

endmodule

// [ocs_stage.sv]
// One overcurrent stage: block sampling, start/trip/block decision,
// DT or IDMT timing, time-stamped events, counters and fault records.
// Assumes magnitudes, harmonic ratio, time and group come from logic on
// i_sys_clk; only i_block is an asynchronous pin.
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/1ps
module ocs_stage
  import ocs_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = PROG_CYC,
  parameter int unsigned MS_CYCLES   = MS_CYC
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        i_block,
  input  wire logic [15:0] i_mag_a,
  input  wire logic [15:0] i_mag_b,
  input  wire logic [15:0] i_mag_c,
  input  wire logic [15:0] i_harm2_ratio,
  input  wire logic [47:0] i_time_ms,
  input  wire logic [2:0]  i_setting_group,
  input  wire logic        i_evt_ready,
  output ocs_evt_t         o_evt,
  output logic             o_start,
  output logic             o_trip,
  output logic             o_blocked,
  output logic [2:0]       o_start_ph,
  output logic [2:0]       o_trip_ph
);

  initial begin
    if (PROG_CYCLES < 2 || PROG_CYCLES > 2**20 || MS_CYCLES < 2 ||
        MS_CYCLES > 2**20) begin
      $error("ocs_stage: cycle counts out of range");
    end
  end

  typedef enum logic [2:0] {
    OCS_IDLE,
    OCS_START,
    OCS_TRIP,
    OCS_BLOCKED,
    OCS_RELEASE
  } ocs_state_t;

  //////////////////////////////////////////////////////////////////////////
  // Registers
  logic        idmt_q, inrush_q;
  logic [15:0] iset_q, hlim_q;
  logic [20:0] opdly_q, reldly_q;
  logic [31:0] idmtk_q;
  logic [8:0]  on_en_q, off_en_q;
  logic [3:0]  rsel_idx_q;
  logic [2:0]  rsel_word_q;
  logic        clr_cnt_q;
  logic [15:0] cnt_start_q, cnt_trip_q, cnt_blk_q;
  logic        rd_ok, wr_en, acc_ph;
  logic [31:0] rd_val;
  logic [255:0] rec_flat;
  ocs_rec_t    rd_rec, rec_d;
  logic [3:0]  rec_count;
  ocs_state_t  state_q;
  logic [2:0]  pick_q;

  // One wait state so read data leaves a flip-flop
  assign acc_ph = psel && penable;
  assign wr_en  = acc_ph && pready && pwrite;

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      pready <= 1'b0;
    end else begin
      pready <= acc_ph && !pready;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      idmt_q      <= 1'b0;
      inrush_q    <= 1'b0;
      iset_q      <= ISET_RST;
      hlim_q      <= HLIM_RST;
      opdly_q     <= OPDLY_RST;
      reldly_q    <= RELDLY_RST;
      idmtk_q     <= IDMTK_RST;
      on_en_q     <= EVEN_RST;
      off_en_q    <= EVEN_RST;
      rsel_idx_q  <= 4'h0;
      rsel_word_q <= 3'h0;
      clr_cnt_q   <= 1'b0;
    end else begin
      clr_cnt_q <= 1'b0;
      if (wr_en) begin
        case (paddr)
          OFS_CTRL: begin
            idmt_q    <= pwdata[CTRL_IDMT];
            inrush_q  <= pwdata[CTRL_INRUSH];
            clr_cnt_q <= pwdata[CTRL_CLRCNT];
          end
          OFS_ISET:   iset_q   <= pwdata[15:0];
          OFS_HLIM:   hlim_q   <= pwdata[15:0];
          OFS_OPDLY:  opdly_q  <= pwdata[20:0];
          OFS_RELDLY: reldly_q <= pwdata[20:0];
          OFS_IDMTK:  idmtk_q  <= pwdata;
          OFS_ONEN:   on_en_q  <= pwdata[8:0];
          OFS_OFFEN:  off_en_q <= pwdata[8:0];
          OFS_RSEL: begin
            rsel_idx_q  <= pwdata[3:0];
            rsel_word_q <= pwdata[6:4];
          end
          default: ;
        endcase
      end
    end
  end

  // Padded to eight words so word selects 4 to 7 read zero, never unknown
  assign rec_flat = {131'h0, rd_rec};

  always_comb begin
    rd_ok  = 1'b1;
    rd_val = 32'h0;
    case (paddr)
      OFS_CTRL:   rd_val = {29'h0, 1'b0, inrush_q, idmt_q};
      OFS_ISET:   rd_val = {16'h0, iset_q};
      OFS_HLIM:   rd_val = {16'h0, hlim_q};
      OFS_OPDLY:  rd_val = {11'h0, opdly_q};
      OFS_RELDLY: rd_val = {11'h0, reldly_q};
      OFS_IDMTK:  rd_val = idmtk_q;
      OFS_ONEN:   rd_val = {23'h0, on_en_q};
      OFS_OFFEN:  rd_val = {23'h0, off_en_q};
      OFS_STAT:   rd_val = {23'h0, pick_q, o_blocked, o_trip, o_start,
                            state_q};
      OFS_CSTART: rd_val = {16'h0, cnt_start_q};
      OFS_CTRIP:  rd_val = {16'h0, cnt_trip_q};
      OFS_CBLK:   rd_val = {16'h0, cnt_blk_q};
      OFS_RSEL:   rd_val = {25'h0, rsel_word_q, rsel_idx_q};
      OFS_RDATA:  rd_val = rec_flat[32*rsel_word_q +: 32];
      OFS_RCNT:   rd_val = {28'h0, rec_count};
      default:    rd_ok  = 1'b0;
    endcase
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= (acc_ph && !pready && !pwrite) ? rd_val : 32'h0;
      pslverr <= acc_ph && !pready && !rd_ok;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Rate enables and block sampling
  logic [19:0] prog_cnt_q, ms_cnt_q;
  logic        prog_tick, ms_tick;
  logic        blk_s1_q, blk_s2_q, blk_ext_q, inrush_blk, blocked_now;

  assign prog_tick = (prog_cnt_q == 20'(PROG_CYCLES - 1));
  assign ms_tick   = (ms_cnt_q == 20'(MS_CYCLES - 1));

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      prog_cnt_q <= 20'h0;
      ms_cnt_q   <= 20'h0;
    end else begin
      prog_cnt_q <= prog_tick ? 20'h0 : prog_cnt_q + 20'h1;
      ms_cnt_q   <= ms_tick ? 20'h0 : ms_cnt_q + 20'h1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      blk_s1_q  <= 1'b0;
      blk_s2_q  <= 1'b0;
      blk_ext_q <= 1'b0;
    end else begin
      blk_s1_q <= i_block;
      blk_s2_q <= blk_s1_q;
      // Held for the whole cycle, so a late block can miss a short delay
      if (prog_tick) begin
        blk_ext_q <= blk_s2_q;
      end
    end
  end

  assign inrush_blk  = inrush_q && (i_harm2_ratio >= hlim_q);
  assign blocked_now = blk_ext_q || inrush_blk;

  //////////////////////////////////////////////////////////////////////////
  // Pick-up with 97 percent reset ratio, per phase
  logic [2:0]  pick_any;
  logic [15:0] mag [3];
  logic [15:0] mag_max;
  logic        pickup;

  assign mag[0] = i_mag_a;
  assign mag[1] = i_mag_b;
  assign mag[2] = i_mag_c;

  for (genvar p = 0; p < 3; p++) begin : g_ph
    always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
        pick_q[p] <= 1'b0;
      end else if (mag[p] > iset_q) begin
        pick_q[p] <= 1'b1;
      end else if (24'(mag[p]) * 24'(FULL_PCT) <
                   24'(iset_q) * 24'(RESET_PCT)) begin
        pick_q[p] <= 1'b0;
      end
    end
  end

  assign pick_any = pick_q;
  assign pickup   = |pick_any;

  always_comb begin
    mag_max = i_mag_a;
    if (i_mag_b > mag_max) mag_max = i_mag_b;
    if (i_mag_c > mag_max) mag_max = i_mag_c;
  end

  //////////////////////////////////////////////////////////////////////////
  // Stage sequence and timing
  logic [20:0] tmr_q;
  logic [31:0] acc_q;
  logic        op_done;

  assign op_done = idmt_q ? (acc_q >= idmtk_q) : (tmr_q >= opdly_q);

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      state_q <= OCS_IDLE;
      tmr_q   <= 21'h0;
      acc_q   <= 32'h0;
    end else begin
      case (state_q)
        OCS_IDLE: begin
          tmr_q <= 21'h0;
          acc_q <= 32'h0;
          if (pickup && blocked_now) begin
            state_q <= OCS_BLOCKED;
          end else if (pickup) begin
            state_q <= OCS_START;
          end
        end
        OCS_START: begin
          if (blocked_now || !pickup) begin
            state_q <= OCS_RELEASE;
            tmr_q   <= 21'h0;
          end else if (op_done) begin
            state_q <= OCS_TRIP;
          end else if (ms_tick) begin
            tmr_q <= tmr_q + 21'h1;
            if (mag_max > iset_q) begin
              acc_q <= acc_q + 32'(mag_max - iset_q);
            end
          end
        end
        OCS_TRIP: begin
          if (!pickup) begin
            state_q <= OCS_IDLE;
          end
        end
        OCS_BLOCKED: begin
          // Nothing further while the block stands
          if (!pickup || !blocked_now) begin
            state_q <= OCS_IDLE;
          end
        end
        OCS_RELEASE: begin
          if (pickup && !blocked_now) begin
            state_q <= OCS_START;
          end else if (pickup && blocked_now) begin
            state_q <= OCS_BLOCKED;
          end else if (tmr_q >= reldly_q) begin
            state_q <= OCS_IDLE;
          end else if (ms_tick) begin
            tmr_q <= tmr_q + 21'h1;
          end
        end
        default: state_q <= OCS_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_start    <= 1'b0;
      o_trip     <= 1'b0;
      o_blocked  <= 1'b0;
      o_start_ph <= 3'h0;
      o_trip_ph  <= 3'h0;
    end else begin
      o_start    <= (state_q == OCS_START) || (state_q == OCS_TRIP);
      o_trip     <= (state_q == OCS_TRIP);
      o_blocked  <= (state_q == OCS_BLOCKED);
      o_start_ph <= (state_q == OCS_START || state_q == OCS_TRIP) ?
                    pick_q : 3'h0;
      o_trip_ph  <= (state_q == OCS_TRIP) ? pick_q : 3'h0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Events: one pending flag per edge, drained lowest index first
  logic [8:0]  cur, prev_q, rise, fall, pend_on_q, pend_off_q;
  logic [8:0]  take_on, take_off;
  logic [47:0] ev_ts_q [NUM_EVT];
  logic        can_emit;

  assign cur  = {o_trip_ph, o_start_ph, o_blocked, o_trip, o_start};
  assign rise = cur & ~prev_q;
  assign fall = ~cur & prev_q;
  assign can_emit = !o_evt.valid || i_evt_ready;

  always_comb begin
    take_on  = 9'h0;
    take_off = 9'h0;
    if (can_emit) begin
      for (int i = NUM_EVT - 1; i >= 0; i--) begin
        if (pend_off_q[i]) begin
          take_on  = 9'h0;
          take_off = 9'h1 << i;
        end
        if (pend_on_q[i]) begin
          take_on  = 9'h1 << i;
          take_off = 9'h0;
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      prev_q     <= 9'h0;
      pend_on_q  <= 9'h0;
      pend_off_q <= 9'h0;
    end else begin
      prev_q <= cur;
      // A new edge wins over the drain of the same flag
      pend_on_q  <= (pend_on_q & ~take_on) | (rise & on_en_q);
      pend_off_q <= (pend_off_q & ~take_off) | (fall & off_en_q);
    end
  end

  for (genvar e = 0; e < NUM_EVT; e++) begin : g_ev
    always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
        ev_ts_q[e] <= 48'h0;
      end else if (rise[e] || fall[e]) begin
        ev_ts_q[e] <= i_time_ms;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_evt <= '0;
    end else if (can_emit) begin
      o_evt.valid <= |(take_on | take_off);
      o_evt.idx   <= 4'h0;
      o_evt.on    <= |take_on;
      o_evt.ts    <= 48'h0;
      for (int i = 0; i < NUM_EVT; i++) begin
        if (take_on[i] || take_off[i]) begin
          o_evt.idx <= 4'(i);
          o_evt.ts  <= ev_ts_q[i];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Counters
  always_ff @(posedge i_sys_clk) begin
    if (i_reset || clr_cnt_q) begin
      cnt_start_q <= 16'h0;
      cnt_trip_q  <= 16'h0;
      cnt_blk_q   <= 16'h0;
    end else begin
      if (rise[EV_START]) cnt_start_q <= cnt_start_q + 16'h1;
      if (rise[EV_TRIP])  cnt_trip_q  <= cnt_trip_q + 16'h1;
      if (rise[EV_BLOCK]) cnt_blk_q   <= cnt_blk_q + 16'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Current history in 20 ms steps; slot 0 is -20 ms, last is -200 ms
  logic [15:0] hist_q [HIST_DEPTH];
  logic [4:0]  hstep_q;
  logic [15:0] prefault_q;

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      hstep_q <= 5'h0;
    end else if (ms_tick) begin
      hstep_q <= (hstep_q == 5'(HIST_STEP_MS - 1)) ? 5'h0 : hstep_q + 5'h1;
    end
  end

  for (genvar h = 0; h < HIST_DEPTH; h++) begin : g_hist
    always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
        hist_q[h] <= 16'h0;
      end else if (ms_tick && hstep_q == 5'(HIST_STEP_MS - 1)) begin
        hist_q[h] <= (h == 0) ? mag_max : hist_q[(h == 0) ? 0 : h - 1];
      end
    end
  end

  // Pre-fault current frozen at start for the later trip record
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      prefault_q <= 16'h0;
    end else if (rise[EV_START] || rise[EV_BLOCK]) begin
      prefault_q <= hist_q[HIST_DEPTH - 1];
    end
  end

  always_comb begin
    rec_d.ts        = i_time_ms;
    rec_d.kind      = rise[EV_TRIP] ? OCS_K_TRIP :
                      rise[EV_BLOCK] ? OCS_K_BLOCK : OCS_K_START;
    rec_d.phases    = pick_q;
    rec_d.pre_trig  = hist_q[0];
    rec_d.fault     = mag_max;
    rec_d.pre_fault = rise[EV_TRIP] ? prefault_q : hist_q[HIST_DEPTH - 1];
    rec_d.remain    = (idmt_q || tmr_q >= opdly_q) ? 21'h0 : opdly_q - tmr_q;
    rec_d.group     = i_setting_group;
  end

  ocs_rec_store #(
    .DEPTH (REC_DEPTH)
  ) u_rec (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_wr      (rise[EV_START] || rise[EV_TRIP] || rise[EV_BLOCK]),
    .i_rec     (rec_d),
    .i_rd_idx  (rsel_idx_q),
    .o_rd_rec  (rd_rec),
    .o_count   (rec_count)
  );

endmodule

// [ocs_stage_chk.sv]
// Checker for ocs_stage: APB answer timing, stage outputs, event hand-off.
// Assumes it is bound onto ocs_stage; single clock domain.
`timescale 1ns/1ps
module ocs_stage_chk
  import ocs_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = PROG_CYC,
  parameter int unsigned MS_CYCLES   = MS_CYC
) (
  input wire logic        i_sys_clk,
  input wire logic        i_reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        i_evt_ready,
  input wire ocs_evt_t    o_evt,
  input wire logic        o_start,
  input wire logic        o_trip,
  input wire logic        o_blocked
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  ////////////////////////////////////////////////////////////
  // One wait state, then a single-cycle answer
  property p_rdy;
    psel && penable && !$past(penable) |-> !pready ##1 pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("pready timing wrong");
  property p_rdy1;
    pready |=> !pready;
  endproperty
  a_rdy1: assert property (p_rdy1) else $error("pready held");
  property p_err;
    pslverr |-> pready;
  endproperty
  a_err: assert property (p_err) else $error("pslverr alone");
  property p_rd0;
    !pready |-> prdata == 32'h0;
  endproperty
  a_rd0: assert property (p_rd0) else $error("prdata not zero");
  ////////////////////////////////////////////////////////////
  property p_trip;
    $rose(o_trip) |-> o_start && $past(o_start);
  endproperty
  a_trip: assert property (p_trip)
    else $error("trip without start");
  property p_excl;
    o_blocked |-> !o_start && !o_trip;
  endproperty
  a_excl: assert property (p_excl)
    else $error("blocked with start");
  property p_evstart;
    $rose(o_start) |-> ##[1:60] (o_evt.valid && o_evt.idx == 4'h0 && o_evt.on);
  endproperty
  a_evstart: assert property (p_evstart)
    else $error("no start event");
  property p_evidx;
    o_evt.valid |-> o_evt.idx < 4'h9;
  endproperty
  a_evidx: assert property (p_evidx)
    else $error("bad event index");
  // Event must not change while the buffer stalls
  property p_evhold;
    o_evt.valid && !i_evt_ready |=> o_evt.valid && $stable(o_evt);
  endproperty
  a_evhold: assert property (p_evhold)
    else $error("event dropped");
  c_trip: cover property (o_trip);
  c_blk: cover property (o_blocked);
  c_err: cover property (pslverr);
  c_start: cover property ($rose(o_start));
endmodule
bind ocs_stage ocs_stage_chk #(
  .PROG_CYCLES (PROG_CYCLES),
  .MS_CYCLES   (MS_CYCLES)
) chk_u (
  .i_sys_clk   (i_sys_clk),
  .i_reset     (i_reset),
  .psel        (psel),
  .penable     (penable),
  .prdata      (prdata),
  .pready      (pready),
  .pslverr     (pslverr),
  .i_evt_ready (i_evt_ready),
  .o_evt       (o_evt),
  .o_start     (o_start),
  .o_trip      (o_trip),
  .o_blocked   (o_blocked)
);

// [ocs_evt_sink.sv]
// Event buffer model: accepts stage events, remembers ON/OFF seen per index.
// Assumes i_slow from the bench; ready changes only after a clock edge.
`timescale 1ns/1ps
module ocs_evt_sink
  import ocs_pkg::*;
(
  input  wire logic     i_sys_clk,
  input  wire logic     i_reset,
  input  wire logic     i_slow,
  input  wire ocs_evt_t i_evt,
  output logic          o_ready,
  output logic [8:0]    o_on_seen,
  output logic [8:0]    o_off_seen
);
  logic [1:0] cnt_q;
  // Slow mode stalls three cycles in four
  always_ff @(posedge i_sys_clk) begin
    cnt_q   <= i_reset ? 2'h0 : cnt_q + 2'h1;
    o_ready <= !i_reset && (!i_slow || cnt_q == 2'h3);
  end
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_on_seen  <= 9'h000;
      o_off_seen <= 9'h000;
    end else if (i_evt.valid && o_ready) begin
      if (i_evt.on) begin
        o_on_seen[i_evt.idx]  <= 1'b1;
      end else begin
        o_off_seen[i_evt.idx] <= 1'b1;
      end
    end
  end
endmodule

// [tb_top.sv]
// Bench for ocs_stage: APB master, random pick-up, trip, block, inrush.
// Assumes ocs_evt_sink as event buffer and the bound checker.
`timescale 1ns/1ps
module tb_top;
  import ocs_pkg::*;
  localparam logic [15:0] RAT [3] = '{16'h270F, 16'h01F4, 16'h01F3};
  logic        i_sys_clk, i_reset, psel, penable, pwrite, pready;
  logic        pslverr, i_block, i_evt_ready, slow, err_v, b_v;
  logic        o_start, o_trip, o_blocked;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic [15:0] i_mag_a, i_mag_b, i_mag_c, i_harm2_ratio, v;
  logic [47:0] i_time_ms;
  logic [2:0]  i_setting_group, o_start_ph, o_trip_ph;
  logic [8:0]  on_seen, off_seen;
  ocs_evt_t    o_evt;
  int          miscompares, compares, cyc, nst, ntr, nbk;
  ocs_stage #(.PROG_CYCLES(20), .MS_CYCLES(4)) dut_u (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .i_block(i_block), .i_mag_a(i_mag_a), .i_mag_b(i_mag_b),
    .i_mag_c(i_mag_c), .i_harm2_ratio(i_harm2_ratio),
    .i_time_ms(i_time_ms), .i_setting_group(i_setting_group),
    .i_evt_ready(i_evt_ready), .o_evt(o_evt), .o_start(o_start),
    .o_trip(o_trip), .o_blocked(o_blocked), .o_start_ph(o_start_ph),
    .o_trip_ph(o_trip_ph));
  ocs_evt_sink sink_u (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_slow(slow),
    .i_evt(o_evt), .o_ready(i_evt_ready), .o_on_seen(on_seen),
    .o_off_seen(off_seen));
  ////////////////////////////////////////////////////////////
  function automatic logic exp_pick(logic [15:0] m);
    return m > ISET_RST;
  endfunction
  function automatic logic exp_inr(logic en, logic [15:0] r);
    return en && r >= 16'h01F4;
  endfunction
  task automatic test_done();
    if (miscompares == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge i_sys_clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge i_sys_clk);
    penable <= 1'b1;
    do @(posedge i_sys_clk); while (pready !== 1'b1);
    rd_v    = prdata;
    err_v   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), rd_v, e);
  endtask
  task automatic pk(logic [15:0] m, int n);
    @(posedge i_sys_clk);
    i_mag_a <= m;
    i_mag_b <= 16'($urandom_range(0, 1000));
    i_mag_c <= 16'($urandom_range(0, 1000));
    repeat (n) @(posedge i_sys_clk);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end
  // Free-running time base; run limit guards against a hang
  always @(posedge i_sys_clk) begin
    i_time_ms       <= i_time_ms + 48'h1;
    i_setting_group <= 3'($urandom_range(0, 7));
    cyc++;
    if (cyc > 20000) begin
      miscompares++;
      test_done();
    end
  end
  initial begin
    void'($urandom(36));
    {psel, penable, pwrite, i_block, slow} = 5'h00;
    {paddr, pwdata, i_time_ms, i_setting_group} = '0;
    {i_mag_a, i_mag_b, i_mag_c, i_harm2_ratio} = '0;
    i_reset = 1'b1;
    repeat (8) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    rd(OFS_ISET, 32'h04B0);
    rd(OFS_HLIM, 32'h0001);
    rd(OFS_ONEN, 32'h01FF);
    rd(OFS_CTRL, 32'h0000);
    apb(1'b0, 8'h3C, 32'h0);
    chk("slverr", {31'h0, err_v}, 32'h1);
    slow <= 1'b1;
    repeat (12) begin
      v = 16'($urandom_range(600, 2400));
      pk(v, 6);
      b_v = exp_pick(v);
      chk("start", {o_start, o_start_ph}, {b_v, 2'h0, b_v});
      if (b_v) nst++;
      pk(16'h0000, 12);
    end
    slow <= 1'b0;
    apb(1'b1, OFS_OPDLY, 32'h2);
    pk(16'h07D0, 6);
    chk("early", {31'h0, o_trip}, 32'h0);
    repeat (54) @(posedge i_sys_clk);
    chk("trip", {o_start, o_trip, o_trip_ph}, 32'h19);
    nst++;
    ntr++;
    pk(16'h0000, 12);
    @(posedge i_sys_clk);
    i_block <= 1'b1;
    // Block leads pick-up by more than one program cycle
    pk(16'h0000, 30);
    pk(16'h07D0, 60);
    chk("blocked", {o_start, o_trip, o_blocked}, 32'h1);
    nbk++;
    @(posedge i_sys_clk);
    i_block <= 1'b0;
    pk(16'h0000, 30);
    apb(1'b1, OFS_OPDLY, 32'h64);
    apb(1'b1, OFS_HLIM, 32'h01F4);
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, OFS_CTRL, {30'h0, k != 0, 1'b0});
      i_harm2_ratio <= RAT[k];
      pk(16'h0000, 30);
      pk(16'h07D0, 8);
      b_v = exp_inr(k != 0, RAT[k]);
      chk("inrush", {o_start, o_blocked}, {!b_v, b_v});
      if (b_v) nbk++;
      else nst++;
      pk(16'h0000, 30);
    end
    rd(OFS_CSTART, 32'(nst));
    rd(OFS_CTRIP, 32'(ntr));
    rd(OFS_CBLK, 32'(nbk));
    v = 16'(nst + ntr + nbk);
    rd(OFS_RCNT, (v > 16'(REC_DEPTH)) ? 32'(REC_DEPTH) : 32'(v));
    apb(1'b1, OFS_RSEL, 32'h10);
    // Record words hold random history; only the select, fault and kind/phase bits read back exactly
    rd(OFS_RSEL, 32'h10);
    apb(1'b0, OFS_RDATA, 32'h0);
    chk("fault", {16'h0, rd_v[23:8]}, 32'h07D0);
    apb(1'b1, OFS_RSEL, 32'h20);
    apb(1'b0, OFS_RDATA, 32'h0);
    chk("kind", {27'h0, rd_v[12:8]}, 32'h01);
    // Inverse mode: 800 per ms against 0x100 trips long before 100 ms DT
    apb(1'b1, OFS_IDMTK, 32'h100);
    apb(1'b1, OFS_CTRL, 32'h1);
    pk(16'h07D0, 20);
    chk("idmt", {31'h0, o_trip}, 32'h1);
    pk(16'h0000, 12);
    apb(1'b1, OFS_CTRL, 32'h4);
    rd(OFS_CSTART, 32'h0);
    pk(16'h0514, 6);
    pk(16'h0492, 8);
    chk("hold", {31'h0, o_start}, 32'h1);
    pk(16'h048B, 8);
    chk("drop", {31'h0, o_start}, 32'h0);
    pk(16'h0514, 6);
    @(posedge i_sys_clk);
    i_block <= 1'b1;
    repeat (30) @(posedge i_sys_clk);
    chk("restart", {31'h0, o_start}, 32'h0);
    chk("on", {23'h0, on_seen}, 32'h04F);
    chk("off", {23'h0, off_seen}, 32'h04F);
    test_done();
  end
endmodule
